// *** verilog/dgp_defs.vh ***
// Offsets, fields, reset values and counts of the gain, pilot and meter block.
`ifndef DGP_DEFS_VH
`define DGP_DEFS_VH
`define DGP_OFS_CTRL        12'h000
`define DGP_OFS_GAIN_A      12'h004
`define DGP_OFS_GAIN_B      12'h008
`define DGP_OFS_SEED_LO     12'h00C
`define DGP_OFS_SEED_HI     12'h010
`define DGP_OFS_PIL_DELAY   12'h014
`define DGP_OFS_PIL_GAIN0   12'h018
`define DGP_OFS_PIL_GAIN1   12'h01C
`define DGP_OFS_PM_INTEG    12'h020
`define DGP_OFS_PM_SDELAY   12'h024
`define DGP_OFS_PM_INTVL    12'h028
`define DGP_OFS_PM_RES_A    12'h02C
`define DGP_OFS_PM_RES_B    12'h030
`define DGP_OFS_GAIN_ACT    12'h034
`define DGP_CTRL_CDMA       0
`define DGP_CTRL_DIVERSITY  1
`define DGP_CTRL_PM_SYNC_DIS 2
`define DGP_CTRL_SSEL_GAIN  6:4
`define DGP_CTRL_SSEL_PIL   10:8
`define DGP_CTRL_SSEL_PM    14:12
`define DGP_CTRL_MASK       32'h0000_7777
`define DGP_GAIN_RST        16'h2000
`define DGP_GAIN_FRAC_BITS  13
`define DGP_ROUND_HALF      36'h0_0000_1000
`define DGP_LFSR_ONES       18'h3FFFF
`define DGP_FRAME_CHIPS     17'd38400
`define DGP_DIV_HALF        17'd256
`define DGP_PM_START_EXTRA  8'd3
`define DGP_PM_IVL_SHIFT    6
`define DGP_PM_RES_MSB      49
`define DGP_PM_RES_LSB      18
`endif

// *** verilog/dgp_top.v ***
// Channel front end: gain, pilot insertion and power meter.
//
// Functional notes
// - Each sample is multiplied by an unsigned 16-bit gain, scaled by 1/8192.
// - CDMA mode keeps separate gains for signal A and signal B.
// - Written gains are staged and become active on the selected sync event.
// - The pilot sequence is added to UMTS samples before pulse shaping.
// - Two 18-bit LFSRs with distinct taps, XOR-combined, give I and Q pilot bits.
// - Each pilot bit selects plus or minus the signed pilot gain; zero disables.
// - Upper LFSR starts from the programmed 18-bit seed; lower from all ones.
// - Diversity sign: plus first 256 chips, toggle every 512, last 256 minus.
// - One bit selects main pilot (0) or diversity pilot (1).
// - Pilot starts after a programmed chip delay from its sync event, up to 65535.
// - Power meter squares I and Q before pulse shaping, sums and accumulates.
// - Integration window lasts four times the 13-bit count plus one samples.
// - Measurements repeat every 64 times (interval value plus one) samples.
// - Integration starts three plus the 7-bit delay samples after meter sync.
// - At window end the top 32 of 50 accumulator bits are latched, with ready pulse.
// - At interval end both integration and interval counters restart.
// - A meter sync resets all meter counters to zero at once.
// - CDMA mode yields separate A and B results; UMTS mode yields one.
// - In CDMA the A sum holds one Q sample fewer than I; B holds equal counts.
// - A disable bit keeps sync events away from the power meter.
// - The mode bit selects CDMA with signals A and B, or one UMTS signal.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dgp_defs.vh"
module dgp_top #(
   parameter SYNC_W = 8
) (
   input  wire                sys_clk_in,
   input  wire                rst_in,
   input  wire                psel_in,
   input  wire                penable_in,
   input  wire                pwrite_in,
   input  wire [11:0]         paddr_in,
   input  wire [31:0]         pwdata_in,
   output reg  [31:0]         prdata_out,
   output reg                 pready_out,
   output reg                 pslverr_out,
   input  wire [SYNC_W-1:0]   sync_in,
   input  wire                smp_valid_in,
   input  wire                smp_sel_b_in,
   input  wire [17:0]         smp_i_in,
   input  wire [17:0]         smp_q_in,
   output reg                 smp_valid_out,
   output reg                 smp_sel_b_out,
   output reg  [17:0]         smp_i_out,
   output reg  [17:0]         smp_q_out,
   output reg                 pm_ready_out
);

   function [17:0] sat18;
      input signed [35:0] v;
      begin
         if (v > 36'sd131071)
            sat18 = 18'h1FFFF;
         else if (v < -36'sd131072)
            sat18 = 18'h20000;
         else
            sat18 = v[17:0];
      end
   endfunction

   function sel_sync;
      input [SYNC_W-1:0] s;
      input [2:0]        idx;
      begin
         sel_sync = s[idx];
      end
   endfunction

   // Register file.
   reg  [31:0] ctrl_ff;
   reg  [15:0] gain_a_stage_ff;
   reg  [15:0] gain_b_stage_ff;
   reg  [15:0] gain_a_act_ff;
   reg  [15:0] gain_b_act_ff;
   reg  [15:0] seed_lo_ff;
   reg  [1:0]  seed_hi_ff;
   reg  [15:0] pil_delay_ff;
   reg  [15:0] pil_gain0_ff;
   reg  [15:0] pil_gain1_ff;
   reg  [12:0] pm_integ_ff;
   reg  [6:0]  pm_sdelay_ff;
   reg  [9:0]  pm_intvl_ff;
   reg  [31:0] pm_res_a_ff;
   reg  [31:0] pm_res_b_ff;

   wire cdma      = ctrl_ff[`DGP_CTRL_CDMA];
   wire diversity = ctrl_ff[`DGP_CTRL_DIVERSITY];
   wire sync_gain = sel_sync(sync_in, ctrl_ff[`DGP_CTRL_SSEL_GAIN]);
   wire sync_pil  = sel_sync(sync_in, ctrl_ff[`DGP_CTRL_SSEL_PIL]);
   wire sync_pm   = sel_sync(sync_in, ctrl_ff[`DGP_CTRL_SSEL_PM])
                    & ~ctrl_ff[`DGP_CTRL_PM_SYNC_DIS];

   // APB: one wait state, the transfer completes on the edge that sees pready high.
   wire        apb_acc  = psel_in & penable_in;
   wire        apb_wr   = apb_acc & pready_out & pwrite_in;
   reg  [31:0] rd_mux;
   reg         addr_ok;

   always @* begin
      rd_mux  = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr_in)
         `DGP_OFS_CTRL:      rd_mux = ctrl_ff;
         `DGP_OFS_GAIN_A:    rd_mux = {16'h0000, gain_a_stage_ff};
         `DGP_OFS_GAIN_B:    rd_mux = {16'h0000, gain_b_stage_ff};
         `DGP_OFS_SEED_LO:   rd_mux = {16'h0000, seed_lo_ff};
         `DGP_OFS_SEED_HI:   rd_mux = {30'h0, seed_hi_ff};
         `DGP_OFS_PIL_DELAY: rd_mux = {16'h0000, pil_delay_ff};
         `DGP_OFS_PIL_GAIN0: rd_mux = {16'h0000, pil_gain0_ff};
         `DGP_OFS_PIL_GAIN1: rd_mux = {16'h0000, pil_gain1_ff};
         `DGP_OFS_PM_INTEG:  rd_mux = {19'h0, pm_integ_ff};
         `DGP_OFS_PM_SDELAY: rd_mux = {25'h0, pm_sdelay_ff};
         `DGP_OFS_PM_INTVL:  rd_mux = {22'h0, pm_intvl_ff};
         `DGP_OFS_PM_RES_A:  rd_mux = pm_res_a_ff;
         `DGP_OFS_PM_RES_B:  rd_mux = pm_res_b_ff;
         `DGP_OFS_GAIN_ACT:  rd_mux = {gain_b_act_ff, gain_a_act_ff};
         default:            addr_ok = 1'b0;
      endcase
   end

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (apb_acc & ~pready_out) begin
         pready_out  <= 1'b1;
         prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
         pslverr_out <= ~addr_ok;
      end else begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end
   end

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         ctrl_ff         <= 32'h0000_0000;
         gain_a_stage_ff <= `DGP_GAIN_RST;
         gain_b_stage_ff <= `DGP_GAIN_RST;
         gain_a_act_ff   <= `DGP_GAIN_RST;
         gain_b_act_ff   <= `DGP_GAIN_RST;
         seed_lo_ff      <= 16'h0000;
         seed_hi_ff      <= 2'h0;
         pil_delay_ff    <= 16'h0000;
         pil_gain0_ff    <= 16'h0000;
         pil_gain1_ff    <= 16'h0000;
         pm_integ_ff     <= 13'h0000;
         pm_sdelay_ff    <= 7'h00;
         pm_intvl_ff     <= 10'h000;
      end else begin
         if (apb_wr) begin
            case (paddr_in)
               `DGP_OFS_CTRL:      ctrl_ff         <= pwdata_in & `DGP_CTRL_MASK;
               `DGP_OFS_GAIN_A:    gain_a_stage_ff <= pwdata_in[15:0];
               `DGP_OFS_GAIN_B:    gain_b_stage_ff <= pwdata_in[15:0];
               `DGP_OFS_SEED_LO:   seed_lo_ff      <= pwdata_in[15:0];
               `DGP_OFS_SEED_HI:   seed_hi_ff      <= pwdata_in[1:0];
               `DGP_OFS_PIL_DELAY: pil_delay_ff    <= pwdata_in[15:0];
               `DGP_OFS_PIL_GAIN0: pil_gain0_ff    <= pwdata_in[15:0];
               `DGP_OFS_PIL_GAIN1: pil_gain1_ff    <= pwdata_in[15:0];
               `DGP_OFS_PM_INTEG:  pm_integ_ff     <= pwdata_in[12:0];
               `DGP_OFS_PM_SDELAY: pm_sdelay_ff    <= pwdata_in[6:0];
               `DGP_OFS_PM_INTVL:  pm_intvl_ff     <= pwdata_in[9:0];
               default:            ctrl_ff         <= ctrl_ff;
            endcase
         end
         if (sync_gain) begin
            gain_a_act_ff <= gain_a_stage_ff;
            gain_b_act_ff <= gain_b_stage_ff;
         end
      end
   end

   // Gain stage.
   wire        is_b      = cdma & smp_sel_b_in;
   wire [15:0] gain_sel  = is_b ? gain_b_act_ff : gain_a_act_ff;
   wire signed [34:0] prod_i = $signed(smp_i_in) * $signed({1'b0, gain_sel});
   wire signed [34:0] prod_q = $signed(smp_q_in) * $signed({1'b0, gain_sel});
   wire signed [35:0] rnd_i  = ($signed({prod_i[34], prod_i}) + $signed(`DGP_ROUND_HALF))
                               >>> `DGP_GAIN_FRAC_BITS;
   wire signed [35:0] rnd_q  = ($signed({prod_q[34], prod_q}) + $signed(`DGP_ROUND_HALF))
                               >>> `DGP_GAIN_FRAC_BITS;
   reg         g_valid_ff;
   reg         g_b_ff;
   reg  [17:0] g_i_ff;
   reg  [17:0] g_q_ff;

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         g_valid_ff <= 1'b0;
         g_b_ff     <= 1'b0;
         g_i_ff     <= 18'h00000;
         g_q_ff     <= 18'h00000;
      end else begin
         g_valid_ff <= smp_valid_in;
         if (smp_valid_in) begin
            g_b_ff <= is_b;
            g_i_ff <= sat18(rnd_i);
            g_q_ff <= sat18(rnd_q);
         end
      end
   end

   // Pilot generator: one chip per UMTS sample.
   wire        chip     = smp_valid_in & ~cdma;
   reg  [17:0] lfsr_x_ff;
   reg  [17:0] lfsr_y_ff;
   reg  [16:0] pil_dly_ff;
   reg  [16:0] frame_cnt_ff;
   reg         pil_wait_ff;
   reg         pil_run_ff;
   wire [17:0] seed     = {seed_hi_ff, seed_lo_ff};
   wire        x_fb     = lfsr_x_ff[0] ^ lfsr_x_ff[7];
   wire        y_fb     = lfsr_y_ff[0] ^ lfsr_y_ff[5] ^ lfsr_y_ff[7] ^ lfsr_y_ff[10];
   wire        pil_bit_i = lfsr_x_ff[0] ^ lfsr_y_ff[0];
   wire        pil_bit_q = (lfsr_x_ff[4] ^ lfsr_x_ff[6] ^ lfsr_x_ff[15])
                          ^ (lfsr_y_ff[5] ^ lfsr_y_ff[6] ^ (^lfsr_y_ff[15:8]));
   wire [16:0] frame_ofs = frame_cnt_ff + `DGP_DIV_HALF;
   wire        div_neg   = diversity & frame_ofs[9];
   wire        frame_end = (frame_cnt_ff == `DGP_FRAME_CHIPS - 17'd1);

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         lfsr_x_ff    <= `DGP_LFSR_ONES;
         lfsr_y_ff    <= `DGP_LFSR_ONES;
         pil_dly_ff   <= 17'h00000;
         frame_cnt_ff <= 17'h00000;
         pil_wait_ff  <= 1'b0;
         pil_run_ff   <= 1'b0;
      end else if (sync_pil) begin
         pil_dly_ff  <= {1'b0, pil_delay_ff};
         pil_wait_ff <= 1'b1;
         pil_run_ff  <= 1'b0;
      end else if (chip) begin
         if (pil_wait_ff) begin
            if (pil_dly_ff == 17'h00000) begin
               pil_wait_ff  <= 1'b0;
               pil_run_ff   <= 1'b1;
               frame_cnt_ff <= 17'h00000;
               lfsr_x_ff    <= seed;
               lfsr_y_ff    <= `DGP_LFSR_ONES;
            end else begin
               pil_dly_ff <= pil_dly_ff - 17'h00001;
            end
         end else if (pil_run_ff) begin
            if (frame_end) begin
               frame_cnt_ff <= 17'h00000;
               lfsr_x_ff    <= seed;
               lfsr_y_ff    <= `DGP_LFSR_ONES;
            end else begin
               frame_cnt_ff <= frame_cnt_ff + 17'h00001;
               lfsr_x_ff    <= {x_fb, lfsr_x_ff[17:1]};
               lfsr_y_ff    <= {y_fb, lfsr_y_ff[17:1]};
            end
         end
      end
   end

   // Pilot term: a zero gain inserts nothing.
   wire signed [17:0] pg_i = {{2{pil_gain0_ff[15]}}, pil_gain0_ff};
   wire signed [17:0] pg_q = {{2{pil_gain1_ff[15]}}, pil_gain1_ff};
   reg  signed [17:0] pil_i_ff;
   reg  signed [17:0] pil_q_ff;

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         pil_i_ff <= 18'h00000;
         pil_q_ff <= 18'h00000;
      end else if (smp_valid_in) begin
         if (pil_run_ff & ~cdma) begin
            pil_i_ff <= (pil_bit_i ^ div_neg) ? -pg_i : pg_i;
            pil_q_ff <= (pil_bit_q ^ div_neg) ? -pg_q : pg_q;
         end else begin
            pil_i_ff <= 18'h00000;
            pil_q_ff <= 18'h00000;
         end
      end
   end

   wire signed [35:0] sum_i = $signed(g_i_ff) + pil_i_ff;
   wire signed [35:0] sum_q = $signed(g_q_ff) + pil_q_ff;

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         smp_valid_out <= 1'b0;
         smp_sel_b_out <= 1'b0;
         smp_i_out     <= 18'h00000;
         smp_q_out     <= 18'h00000;
      end else begin
         smp_valid_out <= g_valid_ff;
         if (g_valid_ff) begin
            smp_sel_b_out <= g_b_ff;
            smp_i_out     <= sat18(sum_i);
            smp_q_out     <= sat18(sum_q);
         end
      end
   end

   // Power meter on the pilot-summed samples ahead of the filters.
   localparam PM_IDLE  = 2'd0;
   localparam PM_DELAY = 2'd1;
   localparam PM_INTEG = 2'd2;
   localparam PM_WAIT  = 2'd3;
   reg  [1:0]  pm_state_ff;
   reg  [7:0]  pm_dly_ff;
   reg  [15:0] pm_icnt_ff;
   reg  [16:0] pm_ivl_ff;
   reg  [49:0] acc_a_ff;
   reg  [49:0] acc_b_ff;
   wire        pm_tick   = smp_valid_out & ~(cdma & smp_sel_b_out);
   wire        pm_b_smp  = smp_valid_out & cdma & smp_sel_b_out;
   wire [35:0] sq_i      = $signed(smp_i_out) * $signed(smp_i_out);
   wire [35:0] sq_q      = $signed(smp_q_out) * $signed(smp_q_out);
   wire        skip_q    = cdma & (pm_icnt_ff == 16'h0000);
   wire [49:0] pwr       = {14'h0000, sq_i} + {14'h0000, (skip_q ? 36'h0_0000_0000 : sq_q)};
   wire [49:0] pwr_b     = {14'h0000, sq_i} + {14'h0000, sq_q};
   wire [15:0] win_len   = {1'b0, pm_integ_ff, 2'b00} + 16'h0001;
   wire [16:0] ivl_len   = {pm_intvl_ff, 6'h00} + 17'h00040;
   wire        win_done  = (pm_icnt_ff == win_len);
   wire        ivl_done  = (pm_ivl_ff == ivl_len - 17'h00001);

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         pm_state_ff  <= PM_IDLE;
         pm_dly_ff    <= 8'h00;
         pm_icnt_ff   <= 16'h0000;
         pm_ivl_ff    <= 17'h00000;
         acc_a_ff     <= 50'h0;
         acc_b_ff     <= 50'h0;
         pm_res_a_ff  <= 32'h0000_0000;
         pm_res_b_ff  <= 32'h0000_0000;
         pm_ready_out <= 1'b0;
      end else if (sync_pm) begin
         pm_state_ff  <= PM_DELAY;
         pm_dly_ff    <= 8'h00;
         pm_icnt_ff   <= 16'h0000;
         pm_ivl_ff    <= 17'h00000;
         pm_ready_out <= 1'b0;
      end else begin
         pm_ready_out <= 1'b0;
         case (pm_state_ff)
            PM_IDLE: begin
               pm_state_ff <= PM_IDLE;
            end
            PM_DELAY: begin
               if (pm_tick) begin
                  if (pm_dly_ff == {1'b0, pm_sdelay_ff} + `DGP_PM_START_EXTRA - 8'd1) begin
                     pm_state_ff <= PM_INTEG;
                     acc_a_ff    <= 50'h0;
                     acc_b_ff    <= 50'h0;
                  end
                  pm_dly_ff <= pm_dly_ff + 8'd1;
               end
            end
            PM_INTEG: begin
               if (pm_tick) begin
                  pm_ivl_ff <= pm_ivl_ff + 17'h00001;
                  if (win_done) begin
                     pm_res_a_ff  <= acc_a_ff[`DGP_PM_RES_MSB:`DGP_PM_RES_LSB];
                     pm_res_b_ff  <= cdma ? acc_b_ff[`DGP_PM_RES_MSB:`DGP_PM_RES_LSB]
                                          : 32'h0000_0000;
                     pm_ready_out <= 1'b1;
                     pm_state_ff  <= PM_WAIT;
                  end else begin
                     acc_a_ff   <= acc_a_ff + pwr;
                     pm_icnt_ff <= pm_icnt_ff + 16'h0001;
                  end
               end else if (pm_b_smp && pm_icnt_ff != 16'h0000) begin
                  acc_b_ff <= acc_b_ff + pwr_b;
               end
            end
            PM_WAIT: begin
               if (pm_tick) begin
                  if (ivl_done) begin
                     pm_ivl_ff   <= 17'h00000;
                     pm_icnt_ff  <= 16'h0000;
                     acc_a_ff    <= 50'h0;
                     acc_b_ff    <= 50'h0;
                     pm_state_ff <= PM_INTEG;
                  end else begin
                     pm_ivl_ff <= pm_ivl_ff + 17'h00001;
                  end
               end
            end
            default: pm_state_ff <= PM_IDLE;
         endcase
      end
   end

endmodule

// *** sim/dgp_top_properties.sv ***
// Port-level checks for the gain, pilot and power meter block.
`timescale 1ns/1ps
module dgp_top_properties (
   input wire        sys_clk_in,
   input wire        rst_in,
   input wire        psel_in,
   input wire        penable_in,
   input wire [11:0] paddr_in,
   input wire [31:0] prdata_out,
   input wire        pready_out,
   input wire        pslverr_out,
   input wire        smp_valid_in,
   input wire        smp_valid_out,
   input wire [17:0] smp_i_out,
   input wire [17:0] smp_q_out,
   input wire        pm_ready_out
);
   default clocking dgp_cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_access;
      psel_in && penable_in;
   endsequence
   AST_APB_WAIT: assert property (s_setup ##1 s_access |=> pready_out)
      else $error("APB wait state wrong");
   AST_APB_PULSE: assert property (pready_out |=> !pready_out)
      else $error("APB ready too long");
   AST_APB_ERR: assert property (pready_out |->
      pslverr_out == ($past(paddr_in) > 12'h034 || $past(paddr_in[1:0]) != 2'h0))
      else $error("APB error flag wrong");
   AST_APB_IDLE: assert property (!pready_out |-> prdata_out == 32'h0 && !pslverr_out)
      else $error("APB reply outside cycle");
   AST_VALID_LAT: assert property (smp_valid_in |-> ##2 smp_valid_out)
      else $error("sample latency wrong");
   AST_VALID_ONLY: assert property (smp_valid_out |-> $past(smp_valid_in, 2))
      else $error("sample without input");
   AST_OUT_HOLD: assert property (!smp_valid_out |->
      $stable(smp_i_out) && $stable(smp_q_out))
      else $error("sample changed idle");
   AST_PM_GAP: assert property (pm_ready_out |=> !pm_ready_out [*4])
      else $error("power ready too close");
endmodule
bind dgp_top dgp_top_properties u_props (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .smp_valid_in(smp_valid_in),
   .smp_valid_out(smp_valid_out), .smp_i_out(smp_i_out), .smp_q_out(smp_q_out),
   .pm_ready_out(pm_ready_out));

// *** sim/dgp_chan_model.sv ***
// Baseband sample source and downstream sample sink around the block.
`timescale 1ns/1ps
module dgp_chan_model (
   input  wire        clk_in,
   output reg         valid_out,
   output reg         sel_b_out,
   output reg  [17:0] i_out,
   output reg  [17:0] q_out,
   input  wire        valid_in,
   input  wire [17:0] i_in,
   input  wire [17:0] q_in,
   input  wire        ready_in
);
   reg [17:0] got_i;
   reg [17:0] got_q;
   integer    ready_cnt;
   initial begin
      valid_out = 1'b0;
      sel_b_out = 1'b0;
      i_out = 18'h0;
      q_out = 18'h0;
      got_i = 18'h0;
      got_q = 18'h0;
      ready_cnt = 0;
   end
   always @(posedge clk_in) begin
      if (valid_in) begin
         got_i <= i_in;
         got_q <= q_in;
      end
      if (ready_in) ready_cnt <= ready_cnt + 1;
   end
   // The lines show the inverse after a sample, so stale data never passes.
   task send(input [17:0] i, input [17:0] q, input b);
      begin
         @(posedge clk_in);
         valid_out <= 1'b1;
         sel_b_out <= b;
         i_out <= i;
         q_out <= q;
         @(posedge clk_in);
         valid_out <= 1'b0;
         sel_b_out <= ~b;
         i_out <= ~i;
         q_out <= ~q;
         repeat (4) @(posedge clk_in);
         #1;
      end
   endtask
endmodule

// *** sim/duc_gain_pilot_power_meter_test.sv ***
// Self-checking bench for the gain, pilot and power meter block.
`timescale 1ns/1ps
`include "dgp_defs.vh"
module duc_gain_pilot_power_meter_test;
   reg         sys_clk;
   reg         rst, psel, penable, pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   reg  [7:0]  sync;
   wire [31:0] prdata;
   wire        pready, pslverr, vin, bin, vout, bout, pm_rdy;
   wire [17:0] iin, qin, iout, qout;
   integer     fail_count;
   integer     samples_checked;
   integer     r1, r2, z, zd, k, bad, sgn;
   reg  [31:0] rd;
   reg         err;
   reg  [17:0] seq_m [0:319];
   reg  [17:0] seq_d [0:319];
   dgp_top uut (.sys_clk_in(sys_clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .sync_in(sync), .smp_valid_in(vin),
      .smp_sel_b_in(bin), .smp_i_in(iin), .smp_q_in(qin), .smp_valid_out(vout),
      .smp_sel_b_out(bout), .smp_i_out(iout), .smp_q_out(qout), .pm_ready_out(pm_rdy));
   dgp_chan_model src (.clk_in(sys_clk), .valid_out(vin), .sel_b_out(bin), .i_out(iin),
      .q_out(qin), .valid_in(vout), .i_in(iout), .q_in(qout), .ready_in(pm_rdy));
   task chk(input [63:0] seen, input [63:0] exp, input [8*16-1:0] what);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: %0s got %0h want %0h", $time, what, seen, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge sys_clk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'b1;
         n = 0;
         @(posedge sys_clk);
         while (pready !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         if (n >= 20) chk(0, 1, "apb hang");
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task sync_pulse(input [2:0] s);
      begin
         @(posedge sys_clk);
         sync <= 8'h01 << s;
         @(posedge sys_clk);
         sync <= 8'h00;
      end
   endtask
   task sg(input [15:0] g, input [17:0] i, input [17:0] q, input [17:0] ei, input [17:0] eq);
      begin
         apb(1'b1, `DGP_OFS_GAIN_A, {16'h0, g});
         sync_pulse(3'h0);
         src.send(i, q, 1'b0);
         chk(src.got_i, ei, "gain i");
         chk(src.got_q, eq, "gain q");
      end
   endtask
   task t_regs;
      begin
         apb(1'b0, `DGP_OFS_CTRL, 32'h0);
         chk(rd, 32'h0, "ctrl reset");
         apb(1'b0, `DGP_OFS_GAIN_ACT, 32'h0);
         chk(rd, 32'h2000_2000, "gain reset");
         apb(1'b1, 12'h0FC, 32'h1234);
         chk(err, 1'b1, "unmapped");
         apb(1'b1, `DGP_OFS_PM_RES_A, 32'h5555);
         apb(1'b0, `DGP_OFS_PM_RES_A, 32'h0);
         chk(rd, 32'h0, "result ro");
         $display("registers test done");
      end
   endtask
   task t_gain;
      begin
         apb(1'b1, `DGP_OFS_CTRL, 32'h2100);
         apb(1'b1, `DGP_OFS_GAIN_A, 32'h4000);
         src.send(18'd1000, 18'h3FC18, 1'b0);
         chk(src.got_i, 18'd1000, "staged gain");
         sg(16'h4000, 18'd1000, 18'h3FC18, 18'd2000, 18'h3F830);
         sg(16'h1000, 18'd3, 18'h3FFFD, 18'd2, 18'h3FFFF);
         sg(16'h4000, 18'h1FFFF, 18'h20000, 18'h1FFFF, 18'h20000);
         sg(16'hFFFF, 18'd8192, 18'h0, 18'h0FFFF, 18'h0);
         sg(16'h2000, 18'h0, 18'h0, 18'h0, 18'h0);
         $display("gain test done");
      end
   endtask
   task t_cdma;
      begin
         apb(1'b1, `DGP_OFS_CTRL, 32'h2101);
         apb(1'b1, `DGP_OFS_GAIN_B, 32'h6000);
         sync_pulse(3'h0);
         src.send(18'd1000, 18'd1000, 1'b0);
         chk(src.got_i, 18'd1000, "gain a");
         src.send(18'd1000, 18'd1000, 1'b1);
         chk(src.got_q, 18'd3000, "gain b");
         chk(bout, 1'b1, "b marker");
         apb(1'b1, `DGP_OFS_GAIN_B, 32'h2000);
         sync_pulse(3'h0);
         apb(1'b1, `DGP_OFS_CTRL, 32'h2100);
         src.send(18'd1000, 18'd1000, 1'b1);
         chk(bout, 1'b0, "umts marker");
         $display("cdma gain test done");
      end
   endtask
   task ticks(input cdma, input integer n);
      integer base;
      begin
         base = src.ready_cnt;
         r1 = 0;
         r2 = 0;
         for (k = 1; k <= n; k = k + 1) begin
            src.send(18'h10000, 18'h10000, 1'b0);
            if (cdma) src.send(18'h10000, 18'h10000, 1'b1);
            if (src.ready_cnt - base == 1 && r1 == 0) r1 = k;
            if (src.ready_cnt - base == 2 && r2 == 0) r2 = k;
         end
      end
   endtask
   task pm_run(input cdma, input [31:0] ea, input [31:0] eb);
      begin
         apb(1'b1, `DGP_OFS_CTRL, {31'h1080, cdma});
         sync_pulse(3'h2);
         ticks(cdma, 80);
         chk(r1, 9, "first ready");
         chk(r2 - r1, 64, "interval");
         apb(1'b0, `DGP_OFS_PM_RES_A, 32'h0);
         chk(rd, ea, "result a");
         apb(1'b0, `DGP_OFS_PM_RES_B, 32'h0);
         chk(rd, cdma ? eb : 32'h0, "result b");
         sync_pulse(3'h2);
         ticks(cdma, 12);
         chk(r1, 9, "sync restart");
      end
   endtask
   task t_pm;
      begin
         apb(1'b1, `DGP_OFS_CTRL, 32'h2104);
         apb(1'b1, `DGP_OFS_PM_INTEG, 32'h1);
         apb(1'b1, `DGP_OFS_PM_SDELAY, 32'h0);
         apb(1'b1, `DGP_OFS_PM_INTVL, 32'h0);
         sync_pulse(3'h2);
         ticks(1'b0, 20);
         chk(r1, 0, "sync disabled");
         pm_run(1'b0, 32'h0002_8000, 32'h0);
         pm_run(1'b1, 32'h0002_4000, 32'h0002_8000);
         $display("power meter test done");
      end
   endtask
   task pil_run(input div);
      begin
         apb(1'b1, `DGP_OFS_CTRL, {30'h840, div, 1'b0});
         sync_pulse(3'h1);
         for (k = 0; k < 320; k = k + 1) begin
            src.send(18'h0, 18'h0, 1'b0);
            if (div) seq_d[k] = src.got_i;
            else seq_m[k] = src.got_i;
            if (src.got_q !== 18'h0 && src.got_q !== 18'h100 && src.got_q !== 18'h3FF00)
               bad = bad + 1;
         end
      end
   endtask
   task t_pilot;
      begin
         bad = 0;
         sgn = 0;
         apb(1'b1, `DGP_OFS_SEED_LO, 32'h5A5A);
         apb(1'b1, `DGP_OFS_SEED_HI, 32'h2);
         apb(1'b1, `DGP_OFS_PIL_DELAY, 32'h5);
         apb(1'b1, `DGP_OFS_PIL_GAIN0, 32'h100);
         apb(1'b1, `DGP_OFS_PIL_GAIN1, 32'h100);
         pil_run(1'b0);
         pil_run(1'b1);
         z = 0;
         while (z < 20 && seq_m[z] === 18'h0) z = z + 1;
         zd = 0;
         while (zd < 20 && seq_d[zd] === 18'h0) zd = zd + 1;
         chk(z >= 5 && z <= 6, 1'b1, "pilot delay");
         chk(zd, z, "div delay");
         chk(seq_m[z], 18'h3FF00, "seed start");
         for (k = z; k < 320; k = k + 1) begin
            if (seq_m[k] !== 18'h100 && seq_m[k] !== 18'h3FF00) bad = bad + 1;
            if (seq_m[k] === 18'h100) sgn = sgn + 1;
            if (k - z < 256 && seq_d[k] !== seq_m[k]) bad = bad + 1;
            if (k - z >= 256 && seq_d[k] !== (~seq_m[k]) + 18'h1) bad = bad + 1;
         end
         chk(bad, 0, "pilot sign");
         chk(sgn > 20 && sgn < 300 - z, 1'b1, "pilot mix");
         apb(1'b1, `DGP_OFS_PIL_GAIN0, 32'h0);
         apb(1'b1, `DGP_OFS_PIL_GAIN1, 32'h0);
         src.send(18'd77, 18'h0, 1'b0);
         chk({src.got_i, src.got_q}, {18'd77, 18'h0}, "pilot off");
         $display("pilot test done");
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      sync = 8'h0;
      fail_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs;
      t_gain;
      t_cdma;
      t_pm;
      t_pilot;
      final_report;
   end
   initial begin
      #1000000;
      fail_count = fail_count + 1;
      final_report;
   end
endmodule
